/* rtl/clock_freq_control_defines.vh */
`ifndef CLOCK_FREQ_CONTROL_DEFINES_VH
`define CLOCK_FREQ_CONTROL_DEFINES_VH
// ************************************************************
// register map
// ************************************************************
`define FREQ_CTRL_ADDR     12'h000
`define SEQ_STATUS_ADDR    12'h004
`define ADDR_W             12
// ************************************************************
// frequency control fields
// ************************************************************
`define CLKOUT_BIT         11
`define PLL1_BIT           10
`define PLL2_BIT           9
`define CPU_MSB            8
`define CPU_LSB            6
`define BUS_MSB            5
`define BUS_LSB            3
`define PER_MSB            2
`define PER_LSB            0
`define FREQ_USED_MASK     16'h0FFF
`define FREQ_RESET         16'h0E13
`define WORD_STROBE        4'h3
// ************************************************************
// initial values per clock operating mode
// ************************************************************
`define MODE0_INIT         16'h0E1A
`define MODE1_INIT         16'h0E2C
`define MODE2_INIT         16'h0E13
`define MODE3_INIT         16'h0E13
`define MODE4_INIT         16'h0E0A
`define MODE5_INIT         16'h0E0A
`define MODE6_INIT         16'h0808
`define MODE7_INIT         16'h0E13
`endif

/* rtl/clock_freq_control_sequencer.v */
// Behaviour
// - control register is 16 bits; only 16-bit word writes are taken
// - only power-on reset loads it, value chosen by mode pins
// - bits 15..12 read zero; software writes only zero there
// - bit 11 drives external clock pin; zero floats it with pull-up
// - floating the clock pin leaves internal clocks unchanged
// - no pull-up on the floating pin during hardware standby
// - bit 10 uses or bypasses the first PLL
// - bit 9 uses or leaves out the second PLL
// - cpu ratio codes 000..101 give x1,1/2,1/3,1/4,1/6,1/8
// - bus ratio uses the same codes as the cpu ratio
// - peripheral codes 000..100 give 1/2,1/3,1/4,1/6,1/8
// - first PLL 0 to 1 halts cpu, stops clocks, starts watchdog
// - final overflow restores clocks, resumes cpu, watchdog stops
// - second PLL on: first overflow starts it and reloads watchdog
// - bus ratio change with second PLL on waits one overflow
// - bus ratio change with second PLL off applies at once
// - cpu or peripheral ratio change applies at once
// - clock-enable output low while clock unstable or self-refresh; here it falls one cycle after the unstable output rises
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "clock_freq_control_defines.vh"
module clock_freq_control_sequencer (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg         pready,
   output reg  [31:0] prdata,
   output reg         pslverr,
   input  wire [2:0]  mode_pins,
   input  wire        hw_standby,
   input  wire        sdram_self_refresh,
   input  wire        wdt_overflow,
   output reg         wdt_start_q,
   output reg         wdt_reload_q,
   output reg         wdt_stop_q,
   output reg         cpu_halt_q,
   output reg         int_clock_stop_q,
   output reg         first_pll_on_q,
   output reg         second_pll_on_q,
   output reg  [2:0]  cpu_ratio_q,
   output reg  [2:0]  bus_ratio_q,
   output reg  [2:0]  periph_ratio_q,
   output reg         ext_clock_pin_oe_n_q,
   output reg         ext_clock_pull_up_q,
   output reg         ext_clock_unstable_q,
   output reg         ext_clock_enable_q
);
   // ************************************************************
   // states
   // ************************************************************
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_STAB1 = 3'b010;
   localparam [2:0] ST_STAB2 = 3'b100;

   reg  [15:0] freq_q;
   reg  [2:0]  state_q;
   reg         two_phase_q;
   reg  [2:0]  mode_s1_q;
   reg  [2:0]  mode_s2_q;
   reg         stby_s1_q;
   reg         stby_s2_q;
   reg  [1:0]  strap_wait_q;
   reg         loaded_q;
   reg  [15:0] mode_init;
   wire        access;
   wire        commit;
   wire        bad_req;
   wire [15:0] wr_val;
   wire        pll1_rise;
   wire        bus_change;
   wire        busy;

   // ************************************************************
   // mode pin and standby synchronisers
   // ************************************************************
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_s1_q    <= 3'h0;
         mode_s2_q    <= 3'h0;
         stby_s1_q    <= 1'b0;
         stby_s2_q    <= 1'b0;
         strap_wait_q <= 2'h0;
      end else begin
         mode_s1_q <= mode_pins;
         mode_s2_q <= mode_s1_q;
         stby_s1_q <= hw_standby;
         stby_s2_q <= stby_s1_q;
         if (strap_wait_q != 2'h3) begin
            strap_wait_q <= strap_wait_q + 2'h1;
         end
      end
   end

   always @* begin
      case (mode_s2_q)
         3'h0:    mode_init = `MODE0_INIT;
         3'h1:    mode_init = `MODE1_INIT;
         3'h2:    mode_init = `MODE2_INIT;
         3'h3:    mode_init = `MODE3_INIT;
         3'h4:    mode_init = `MODE4_INIT;
         3'h5:    mode_init = `MODE5_INIT;
         3'h6:    mode_init = `MODE6_INIT;
         default: mode_init = `MODE7_INIT;
      endcase
   end

   // ************************************************************
   // apb decode
   // ************************************************************
   assign access = psel & penable & ~pready;
   assign commit = psel & penable & pready & ~pslverr & pwrite &
                   (paddr == `FREQ_CTRL_ADDR);
   assign busy   = (state_q != ST_IDLE) | ~loaded_q;
   // only halfword-lane writes to the control word are legal
   assign bad_req = pwrite ?
                    ((paddr != `FREQ_CTRL_ADDR) |
                     (pstrb != `WORD_STROBE) | busy) :
                    ((paddr != `FREQ_CTRL_ADDR) &
                     (paddr != `SEQ_STATUS_ADDR));
   // reserved bits are never stored
   assign wr_val = pwdata[15:0] & `FREQ_USED_MASK;

   assign pll1_rise  = wr_val[`PLL1_BIT] & ~freq_q[`PLL1_BIT];
   assign bus_change = (wr_val[`BUS_MSB:`BUS_LSB] !=
                        freq_q[`BUS_MSB:`BUS_LSB]);

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= access;
         pslverr <= access & bad_req;
         prdata  <= 32'h00000000;
         if (access & ~pwrite) begin
            if (paddr == `FREQ_CTRL_ADDR) begin
               prdata <= {16'h0000, freq_q};
            end else if (paddr == `SEQ_STATUS_ADDR) begin
               prdata <= {20'h00000, loaded_q, two_phase_q,
                          state_q, ext_clock_enable_q,
                          bus_ratio_q, cpu_halt_q,
                          second_pll_on_q, first_pll_on_q};
            end
         end
      end
   end

   // ************************************************************
   // control register and change sequencer
   // ************************************************************
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         freq_q           <= `FREQ_RESET;
         loaded_q         <= 1'b0;
         state_q          <= ST_IDLE;
         two_phase_q      <= 1'b0;
         wdt_start_q      <= 1'b0;
         wdt_reload_q     <= 1'b0;
         wdt_stop_q       <= 1'b0;
         cpu_halt_q       <= 1'b0;
         int_clock_stop_q <= 1'b0;
         first_pll_on_q   <= 1'b0;
         second_pll_on_q  <= 1'b0;
         cpu_ratio_q      <= 3'h0;
         bus_ratio_q      <= 3'h0;
         periph_ratio_q   <= 3'h0;
      end else begin
         wdt_start_q  <= 1'b0;
         wdt_reload_q <= 1'b0;
         wdt_stop_q   <= 1'b0;
         if (!loaded_q) begin
            if (strap_wait_q == 2'h3) begin
               // strap captured once, after release of reset
               freq_q          <= mode_init;
               loaded_q        <= 1'b1;
               first_pll_on_q  <= mode_init[`PLL1_BIT];
               second_pll_on_q <= mode_init[`PLL2_BIT];
               cpu_ratio_q     <= mode_init[`CPU_MSB:`CPU_LSB];
               bus_ratio_q     <= mode_init[`BUS_MSB:`BUS_LSB];
               periph_ratio_q  <= mode_init[`PER_MSB:`PER_LSB];
            end
         end else begin
            case (state_q)
               ST_IDLE: begin
                  if (commit) begin
                     freq_q <= wr_val;
                     // cpu and peripheral ratios take effect at once
                     cpu_ratio_q    <= wr_val[`CPU_MSB:`CPU_LSB];
                     periph_ratio_q <= wr_val[`PER_MSB:`PER_LSB];
                     first_pll_on_q <= wr_val[`PLL1_BIT];
                     if (!wr_val[`PLL2_BIT]) begin
                        second_pll_on_q <= 1'b0;
                     end else if (!pll1_rise) begin
                        second_pll_on_q <= 1'b1;
                     end
                     if (pll1_rise) begin
                        // the second pll waits for the first overflow
                        state_q          <= ST_STAB1;
                        two_phase_q      <= wr_val[`PLL2_BIT];
                        second_pll_on_q  <= 1'b0;
                        wdt_start_q      <= 1'b1;
                        cpu_halt_q       <= 1'b1;
                        int_clock_stop_q <= 1'b1;
                     end else if (bus_change & freq_q[`PLL2_BIT] &
                                  wr_val[`PLL2_BIT]) begin
                        state_q          <= ST_STAB1;
                        two_phase_q      <= 1'b0;
                        wdt_start_q      <= 1'b1;
                        cpu_halt_q       <= 1'b1;
                        int_clock_stop_q <= 1'b1;
                     end else begin
                        bus_ratio_q <= wr_val[`BUS_MSB:`BUS_LSB];
                     end
                  end
               end
               ST_STAB1: begin
                  if (wdt_overflow) begin
                     if (two_phase_q) begin
                        second_pll_on_q <= 1'b1;
                        wdt_reload_q    <= 1'b1;
                        state_q         <= ST_STAB2;
                     end else begin
                        state_q          <= ST_IDLE;
                        wdt_stop_q       <= 1'b1;
                        cpu_halt_q       <= 1'b0;
                        int_clock_stop_q <= 1'b0;
                        bus_ratio_q <= freq_q[`BUS_MSB:`BUS_LSB];
                     end
                  end
               end
               ST_STAB2: begin
                  if (wdt_overflow) begin
                     state_q          <= ST_IDLE;
                     two_phase_q      <= 1'b0;
                     wdt_stop_q       <= 1'b1;
                     cpu_halt_q       <= 1'b0;
                     int_clock_stop_q <= 1'b0;
                     bus_ratio_q <= freq_q[`BUS_MSB:`BUS_LSB];
                  end
               end
               default: begin
                  state_q          <= ST_IDLE;
                  cpu_halt_q       <= 1'b0;
                  int_clock_stop_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // ************************************************************
   // external clock pin control
   // ************************************************************
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_clock_pin_oe_n_q <= 1'b0;
         ext_clock_pull_up_q  <= 1'b0;
         ext_clock_unstable_q <= 1'b0;
         ext_clock_enable_q   <= 1'b1;
      end else begin
         // pin drive, pull-up, unstable and clock-enable outputs; ratios and plls are untouched here
         ext_clock_pin_oe_n_q <= ~freq_q[`CLKOUT_BIT];
         ext_clock_pull_up_q  <= ~freq_q[`CLKOUT_BIT] &
                                 ~stby_s2_q;
         ext_clock_unstable_q <= (state_q != ST_IDLE) |
                                 (commit & state_q[0] &
                                  (pll1_rise | (bus_change &
                                   freq_q[`PLL2_BIT] &
                                   wr_val[`PLL2_BIT])));
         ext_clock_enable_q   <= ~((state_q != ST_IDLE) |
                                   sdram_self_refresh);
      end
   end

endmodule

/* dv/clock_freq_control_sva.sv */
`timescale 1ns/1ns
module clock_freq_control_sva (
   input logic        sys_clk,
   input logic        rst_n,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [3:0]  pstrb,
   input logic        pready,
   input logic [31:0] prdata,
   input logic        pslverr,
   input logic        hw_standby,
   input logic        wdt_overflow,
   input logic        wdt_start_q,
   input logic        wdt_reload_q,
   input logic        wdt_stop_q,
   input logic        cpu_halt_q,
   input logic        int_clock_stop_q,
   input logic        second_pll_on_q,
   input logic [2:0]  cpu_ratio_q,
   input logic [2:0]  bus_ratio_q,
   input logic [2:0]  periph_ratio_q,
   input logic        ext_clock_pin_oe_n_q,
   input logic        ext_clock_pull_up_q,
   input logic        ext_clock_unstable_q,
   input logic        ext_clock_enable_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ********************
   // sequences
   // ********************
   sequence s_commit;
      psel && penable && pready && pwrite && !pslverr && paddr == 12'h000;
   endsequence
   sequence s_enter;
      wdt_start_q && cpu_halt_q && int_clock_stop_q;
   endsequence
   // ********************
   // properties
   // ********************
   property p_enter; $rose(cpu_halt_q) |-> s_enter; endproperty
   a_enter: assert property (p_enter) else $error("halt without start");
   property p_cause; $rose(cpu_halt_q) |-> $past(pready && pwrite); endproperty
   a_cause: assert property (p_cause) else $error("halt without write");
   property p_exit;
      $fell(cpu_halt_q) |-> wdt_stop_q && $past(wdt_overflow);
   endproperty
   a_exit: assert property (p_exit) else $error("bad resume");
   property p_reload; wdt_reload_q |-> cpu_halt_q && second_pll_on_q; endproperty
   a_reload: assert property (p_reload) else $error("bad reload");
   property p_hold_bus; cpu_halt_q |-> $stable(bus_ratio_q); endproperty
   a_hold_bus: assert property (p_hold_bus) else $error("bus moved");
   property p_apply;
      s_commit |=> cpu_ratio_q == $past(pwdata[8:6]) &&
         periph_ratio_q == $past(pwdata[2:0]);
   endproperty
   a_apply: assert property (p_apply) else $error("ratio late");
   property p_strobe;
      psel && penable && pready && pwrite && pstrb != 4'h3 |-> pslverr;
   endproperty
   a_strobe: assert property (p_strobe) else $error("narrow write taken");
   property p_rsvd;
      psel && pready && !pwrite && paddr == 12'h000 |-> prdata[31:12] == 20'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   property p_cke; $rose(ext_clock_unstable_q) |=> !ext_clock_enable_q; endproperty
   a_cke: assert property (p_cke) else $error("enable high");
   property p_standby; hw_standby [*4] |-> !ext_clock_pull_up_q; endproperty
   a_standby: assert property (p_standby) else $error("pull-up on");
   property p_pin; !ext_clock_pin_oe_n_q |-> !ext_clock_pull_up_q; endproperty
   a_pin: assert property (p_pin) else $error("pull-up while driven");
endmodule
bind clock_freq_control_sequencer clock_freq_control_sva sva_u (.*);

/* dv/clock_freq_control_sequencer_tb_top.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
   fail_count++; $display("[ERR] t=%0t got %0h exp %0h", $time, a, e); end end
module clock_freq_control_sequencer_tb_top;
   logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic        hw_standby, sdram_self_refresh, wdt_overflow, err_v;
   logic        wdt_start_q, wdt_reload_q, wdt_stop_q, cpu_halt_q;
   logic        int_clock_stop_q, first_pll_on_q, second_pll_on_q;
   logic        ext_clock_pin_oe_n_q, ext_clock_pull_up_q;
   logic        ext_clock_unstable_q, ext_clock_enable_q;
   logic [2:0]  mode_pins, cpu_ratio_q, bus_ratio_q, periph_ratio_q;
   logic [3:0]  pstrb;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_v;
   int          fail_count, samples_checked;
   clock_freq_control_sequencer dut_u (.*);
   initial begin
      sys_clk = 1'h0;
      forever #10 sys_clk = ~sys_clk;
   end
   // ********************
   // bus and helpers
   // ********************
   task print_verdict;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s);
      int n;
      n = 0;
      @(posedge sys_clk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'h2, w, a, d, s};
      @(posedge sys_clk);
      penable <= 1'h1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'h1 && n < 16);
      if (n >= 16) begin
         fail_count++;
         print_verdict();
      end
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d, 4'h3);
   endtask
   task tick(input int k);
      repeat (k) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   // the bench stands in for a watchdog already stopped, divided and
   // loaded with keyed word writes; only its overflow pulse is modelled
   task ovf;
      @(posedge sys_clk);
      wdt_overflow <= 1'h1;
      @(posedge sys_clk);
      wdt_overflow <= 1'h0;
      tick(0);
   endtask
   // ********************
   // scenarios
   // ********************
   task t_reset;
      wr(12'h000, 32'h0000_0E13);
      `CHK(err_v, 1'h1)
      apb(1'h0, 12'h000, 32'h0, 4'h0);
      `CHK(rd_v, 32'h0000_0E2C)
      `CHK({first_pll_on_q, second_pll_on_q, ext_clock_pin_oe_n_q}, 3'h6)
      `CHK({cpu_ratio_q, bus_ratio_q, periph_ratio_q}, 9'h02C)
      $display("reset test done");
   endtask
   task t_ratios;
      logic [8:0] tbl [6];
      // permitted ratio combinations only
      tbl = '{9'h008, 9'h00A, 9'h011, 9'h05A, 9'h0A3, 9'h0EC};
      for (int i = 0; i < 6; i++) begin
         wr(12'h000, {16'h0, 4'h0, 3'h6, tbl[i]});
         tick(1);
         `CHK({cpu_ratio_q, bus_ratio_q, periph_ratio_q, cpu_halt_q},
              {tbl[i], 1'h0})
      end
      $display("ratio test done");
   endtask
   task t_bus_fast;
      logic [8:0] tbl [5];
      tbl = '{9'h008, 9'h011, 9'h01A, 9'h023, 9'h02C};
      for (int i = 0; i < 5; i++) begin
         wr(12'h000, {16'h0, 4'h0, 3'h6, tbl[i]});
         tick(1);
         `CHK({bus_ratio_q, cpu_halt_q, second_pll_on_q},
              {tbl[i][5:3], 2'h0})
      end
      $display("fast bus test done");
   endtask
   task t_bus_stab;
      wr(12'h000, 32'h0000_0E2C);
      tick(1);
      `CHK({second_pll_on_q, cpu_halt_q}, 2'h2)
      wr(12'h000, 32'h0000_0E11);
      tick(0);
      `CHK({wdt_start_q, cpu_halt_q, int_clock_stop_q, ext_clock_unstable_q}, 4'hF)
      tick(1);
      `CHK({wdt_start_q, ext_clock_enable_q, bus_ratio_q}, 5'h05)
      wr(12'h000, 32'h0000_0E2C);
      `CHK(err_v, 1'h1)
      apb(1'h0, 12'h004, 32'h0, 4'h0);
      `CHK(rd_v, 32'h0000_092F)
      ovf;
      `CHK({wdt_stop_q, cpu_halt_q, bus_ratio_q}, 5'h12)
      tick(1);
      `CHK({ext_clock_unstable_q, ext_clock_enable_q}, 2'h1)
      $display("slow bus test done");
   endtask
   task t_pll1;
      wr(12'h000, 32'h0000_0A11);
      tick(1);
      `CHK({first_pll_on_q, cpu_halt_q}, 2'h0)
      wr(12'h000, 32'h0000_0E11);
      tick(0);
      `CHK({wdt_start_q, cpu_halt_q, second_pll_on_q}, 3'h6)
      ovf;
      `CHK({wdt_reload_q, cpu_halt_q, second_pll_on_q, wdt_stop_q}, 4'hE)
      ovf;
      `CHK({wdt_stop_q, cpu_halt_q, first_pll_on_q}, 3'h5)
      $display("pll test done");
   endtask
   task t_misc;
      apb(1'h1, 12'h000, 32'h0000_0600, 4'h1);
      `CHK(err_v, 1'h1)
      apb(1'h0, 12'h008, 32'h0, 4'h0);
      `CHK(err_v, 1'h1)
      wr(12'h000, 32'h0000_0611);
      apb(1'h0, 12'h000, 32'h0, 4'h0);
      `CHK(rd_v, 32'h0000_0611)
      `CHK({ext_clock_pin_oe_n_q, ext_clock_pull_up_q, cpu_ratio_q}, 5'h18)
      @(posedge sys_clk);
      hw_standby <= 1'h1;
      sdram_self_refresh <= 1'h1;
      tick(4);
      `CHK({ext_clock_pull_up_q, ext_clock_enable_q}, 2'h0)
      @(posedge sys_clk);
      {hw_standby, sdram_self_refresh} <= 2'h0;
      $display("misc test done");
   endtask
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {hw_standby, sdram_self_refresh, wdt_overflow} = 3'h0;
      mode_pins = 3'h1;
      fail_count = 0;
      samples_checked = 0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'h1;
      t_reset();
      t_ratios();
      t_bus_fast();
      t_bus_stab();
      t_pll1();
      t_misc();
      print_verdict();
   end
endmodule
